// ===== rtl/ial_pkg.sv
// shared types and constants for the integer execute stage
//
// What this block does
// - nor writes the complement of the or of both sources
// - trapping subtract raises overflow instead of writing on signed overflow
// - non-trapping subtract always writes the difference, never raises
// - signed set-less-than-immediate writes 1 when source below immediate, else 0
// - unsigned set-less-than-immediate writes 1 when source below immediate, else 0
// - arithmetic right shifts fill vacated top bits with the sign bit
// - logical right shifts fill vacated top bits with zeros
// - 32-bit left shifts move toward significance by at most 31 places
// - xor writes the exclusive-or of source and register or immediate
// - system call always raises an exception with the syscall cause
// - branch-likely-equal branches on equal, else nullifies the delay slot
// - link-likely-non-negative always links to r31, branches if source not negative
// - return-from-exception restores the saved status state
// - coprocessor branch-likely follows the selected condition, else nullifies
// - word store writes 32 bits, halfword store writes 16 bits
// - store-left and store-right write partial words that complete unaligned stores
// - 64-bit add writes the sum, or raises overflow instead of writing on signed overflow
package ial_pkg;

	localparam int XLEN = 64;
	localparam int WLEN = 32;
	localparam int SR_W = 6;

	localparam logic [SR_W-1:0] SR_RESET  = 6'h00;
	localparam logic [4:0]      LINK_REG  = 5'h1f;
	localparam logic [XLEN-1:0] LINK_OFS  = 64'h0000_0000_0000_0008;
	localparam logic [XLEN-1:0] SLOT_OFS  = 64'h0000_0000_0000_0004;
	localparam logic [4:0]      CAUSE_OVF = 5'h01;
	localparam logic [4:0]      CAUSE_SYS = 5'h02;

	typedef enum logic [4:0] {
		OP_NOP           = 5'b00000,
		OP_NOR           = 5'b00001,
		OP_SUB           = 5'b00010,
		OP_SUBU          = 5'b00011,
		OP_SLTI          = 5'b00100,
		OP_SLTIU         = 5'b00101,
		OP_SRA           = 5'b00110,
		OP_SRAV          = 5'b00111,
		OP_SRL           = 5'b01000,
		OP_SRLV          = 5'b01001,
		OP_SLL           = 5'b01010,
		OP_SLLV          = 5'b01011,
		OP_XOR           = 5'b01100,
		OP_SYSCALL       = 5'b01101,
		OP_BEQL          = 5'b01110,
		OP_BGEZALL       = 5'b01111,
		OP_RFE           = 5'b10000,
		OP_BCTL          = 5'b10001,
		OP_BCFL          = 5'b10010,
		op_store_word    = 5'b10011,
		op_store_half    = 5'b10100,
		OP_STORE_LEFT    = 5'b10101,
		OP_STORE_RIGHT   = 5'b10110,
		OP_DADD          = 5'b10111
	} ial_op_t;

	typedef struct packed {
		logic            valid;
		ial_op_t         op;
		logic            use_imm;
		logic [XLEN-1:0] rs_val;
		logic [XLEN-1:0] rt_val;
		logic [XLEN-1:0] imm;
		logic [4:0]      shamt;
		logic [4:0]      dest;
		logic [1:0]      cop_sel;
		logic [XLEN-1:0] pc;
	} ial_req_t;

	typedef struct packed {
		logic            wr_en;
		logic [4:0]      dest;
		logic [XLEN-1:0] wdata;
	} ial_res_t;

	typedef struct packed {
		logic            resolved;
		logic            taken;
		logic            nullify;
		logic [XLEN-1:0] target;
	} ial_br_t;

	typedef struct packed {
		logic            valid;
		logic [XLEN-1:0] addr;
		logic [3:0]      be;
		logic [WLEN-1:0] data;
	} ial_st_t;

	typedef struct packed {
		logic            valid;
		logic [4:0]      cause;
		logic [XLEN-1:0] epc;
	} ial_exc_t;

endpackage

// ===== rtl/ial_addsub.sv
// adder-subtractor with signed overflow detect
`timescale 1ns/1ns
module ial_addsub
	import ial_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic [W-1:0] a,
	input  wire logic [W-1:0] b,
	input  wire logic         sub,
	output logic      [W-1:0] sum,
	output logic              ovf
);

	if (W < 2) begin : g_bad_width
		$error("ial_addsub needs W of at least 2");
	end

	logic [W-1:0] b_eff;

	always_comb begin
		b_eff = sub ? ~b : b;
		sum   = a + b_eff + {{(W-1){1'b0}}, sub};
		// overflow: operands agree in sign, result disagrees
		ovf   = (a[W-1] == b_eff[W-1]) && (sum[W-1] != a[W-1]);
	end

endmodule

// ===== rtl/ial_shifter.sv
// barrel shifter: left, logical right, arithmetic right
`timescale 1ns/1ns
module ial_shifter
	import ial_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic [W-1:0]         din,
	input  wire logic [$clog2(W)-1:0] amt,
	input  wire logic                 left,
	input  wire logic                 arith,
	output logic      [W-1:0]         dout
);

	if (W < 2 || (W & (W - 1)) != 0) begin : g_bad_width
		$error("ial_shifter needs W a power of two");
	end

	always_comb begin
		if (left)
			dout = din << amt;
		else if (arith)
			dout = W'($signed(din) >>> amt);
		else
			dout = din >> amt;
	end

endmodule

// ===== rtl/ial_exec.sv
// integer execute stage: logic, compare, shift, add/sub, store, branch-likely, traps
`timescale 1ns/1ns
module ial_exec
	import ial_pkg::*;
(
	input  wire logic            mclk,
	input  wire logic            rstn,
	input  wire ial_req_t        req,
	input  wire logic [3:0]      cp_cond,
	output ial_res_t             res_o,
	output ial_br_t              br_o,
	output ial_st_t              st_o,
	output ial_exc_t             exc_o,
	output logic      [SR_W-1:0] status_o
);

	// ***********************************************
	// operand paths
	// ***********************************************
	ial_res_t        res_reg, res_next;
	ial_br_t         br_reg, br_next;
	ial_st_t         st_reg, st_next;
	ial_exc_t        exc_reg, exc_next;
	logic [SR_W-1:0] sr_reg, sr_next;
	ial_req_t        req_q;

	logic [XLEN-1:0] op2;
	logic [WLEN-1:0] sub32;
	logic            sub32_ovf;
	logic [XLEN-1:0] add64;
	logic            add64_ovf;
	logic [WLEN-1:0] shout;
	logic [4:0]      shamt;
	logic            sh_var;
	logic            sh_left;
	logic            sh_arith;
	logic [XLEN-1:0] st_addr;
	logic [XLEN-1:0] br_tgt;
	logic [1:0]      lane;

	function automatic logic [XLEN-1:0] sext32(input logic [WLEN-1:0] v);
		sext32 = {{(XLEN-WLEN){v[WLEN-1]}}, v};
	endfunction

	assign op2      = req.use_imm ? req.imm : req.rt_val;
	assign sh_var   = (req.op == OP_SRAV) || (req.op == OP_SRLV) || (req.op == OP_SLLV);
	assign shamt    = sh_var ? req.rt_val[4:0] : req.shamt;
	assign sh_left  = (req.op == OP_SLL) || (req.op == OP_SLLV);
	assign sh_arith = (req.op == OP_SRA) || (req.op == OP_SRAV);
	assign st_addr  = req.rs_val + req.imm;
	assign lane     = st_addr[1:0];
	assign br_tgt   = req.pc + SLOT_OFS + {req.imm[XLEN-3:0], 2'b00};

	ial_addsub #(
		.W(WLEN)
	) u_sub32 (
		.a   (req.rs_val[WLEN-1:0]),
		.b   (op2[WLEN-1:0]),
		.sub (1'b1),
		.sum (sub32),
		.ovf (sub32_ovf)
	);

	ial_addsub #(
		.W(XLEN)
	) u_add64 (
		.a   (req.rs_val),
		.b   (req.rt_val),
		.sub (1'b0),
		.sum (add64),
		.ovf (add64_ovf)
	);

	ial_shifter #(
		.W(WLEN)
	) u_shift (
		.din   (req.rs_val[WLEN-1:0]),
		.amt   (shamt),
		.left  (sh_left),
		.arith (sh_arith),
		.dout  (shout)
	);

	// ***********************************************
	// next-state logic
	// ***********************************************
	always_comb begin
		res_next      = '0;
		br_next       = '0;
		st_next       = '0;
		exc_next      = '0;
		sr_next       = sr_reg;
		res_next.dest = req.dest;
		exc_next.epc  = req.pc;
		if (req.valid) begin
			case (req.op)
				OP_NOR: begin
					res_next.wr_en = 1'b1;
					res_next.wdata = ~(req.rs_val | op2);
				end
				OP_SUB: begin
					if (sub32_ovf) begin
						exc_next.valid = 1'b1;
						exc_next.cause = CAUSE_OVF;
					end else begin
						res_next.wr_en = 1'b1;
						res_next.wdata = sext32(sub32);
					end
				end
				OP_SUBU: begin
					res_next.wr_en = 1'b1;
					res_next.wdata = sext32(sub32);
				end
				OP_SLTI: begin
					res_next.wr_en = 1'b1;
					res_next.wdata = {63'h0, $signed(req.rs_val) < $signed(req.imm)};
				end
				OP_SLTIU: begin
					res_next.wr_en = 1'b1;
					res_next.wdata = {63'h0, req.rs_val < req.imm};
				end
				OP_SRA, OP_SRAV, OP_SRL, OP_SRLV, OP_SLL, OP_SLLV: begin
					res_next.wr_en = 1'b1;
					res_next.wdata = sext32(shout);
				end
				OP_XOR: begin
					res_next.wr_en = 1'b1;
					res_next.wdata = req.rs_val ^ op2;
				end
				OP_SYSCALL: begin
					exc_next.valid = 1'b1;
					exc_next.cause = CAUSE_SYS;
				end
				OP_BEQL: begin
					br_next.resolved = 1'b1;
					br_next.taken    = req.rs_val == op2;
					br_next.nullify  = req.rs_val != op2;
					br_next.target   = br_tgt;
				end
				OP_BGEZALL: begin
					res_next.wr_en   = 1'b1;
					res_next.dest    = LINK_REG;
					res_next.wdata   = req.pc + LINK_OFS;
					br_next.resolved = 1'b1;
					br_next.taken    = ~req.rs_val[XLEN-1];
					br_next.nullify  = req.rs_val[XLEN-1];
					br_next.target   = br_tgt;
				end
				OP_RFE: begin
					sr_next = {sr_reg[5:4], sr_reg[5:2]};
				end
				OP_BCTL, OP_BCFL: begin
					br_next.resolved = 1'b1;
					br_next.taken    = cp_cond[req.cop_sel] == (req.op == OP_BCTL);
					br_next.nullify  = cp_cond[req.cop_sel] != (req.op == OP_BCTL);
					br_next.target   = br_tgt;
				end
				op_store_word: begin
					st_next.valid = 1'b1;
					st_next.be    = 4'hf;
					st_next.data  = req.rt_val[WLEN-1:0];
				end
				op_store_half: begin
					st_next.valid = 1'b1;
					st_next.be    = lane[1] ? 4'hc : 4'h3;
					st_next.data  = {2{req.rt_val[15:0]}};
				end
				OP_STORE_LEFT: begin
					// high bytes of the register land at and below the address
					st_next.valid = 1'b1;
					st_next.be    = 4'(4'hf >> (2'h3 - lane));
					st_next.data  = req.rt_val[WLEN-1:0] >> {(2'h3 - lane), 3'b000};
				end
				OP_STORE_RIGHT: begin
					// low bytes of the register land at and above the address
					st_next.valid = 1'b1;
					st_next.be    = 4'(4'hf << lane);
					st_next.data  = req.rt_val[WLEN-1:0] << {lane, 3'b000};
				end
				OP_DADD: begin
					if (add64_ovf) begin
						exc_next.valid = 1'b1;
						exc_next.cause = CAUSE_OVF;
					end else begin
						res_next.wr_en = 1'b1;
						res_next.wdata = add64;
					end
				end
				default: begin
					res_next.wr_en = 1'b0;
				end
			endcase
			st_next.addr = st_addr;
		end
		// taking an exception pushes the mode/enable stack
		if (exc_next.valid)
			sr_next = {sr_reg[3:0], 2'b00};
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			res_reg <= '0;
			br_reg  <= '0;
			st_reg  <= '0;
			exc_reg <= '0;
			sr_reg  <= SR_RESET;
			req_q   <= '0;
		end else begin
			res_reg <= res_next;
			br_reg  <= br_next;
			st_reg  <= st_next;
			exc_reg <= exc_next;
			sr_reg  <= sr_next;
			req_q   <= req;
		end
	end

	assign res_o    = res_reg;
	assign br_o     = br_reg;
	assign st_o     = st_reg;
	assign exc_o    = exc_reg;
	assign status_o = sr_reg;

	// ***********************************************
	// assertions
	// ***********************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	logic q_ok;
	assign q_ok = req_q.valid;

	a_nor_value: assert property (
		q_ok && req_q.op == OP_NOR |-> res_reg.wr_en
		&& res_reg.wdata == ~(req_q.rs_val | (req_q.use_imm ? req_q.imm : req_q.rt_val)))
		else $error("nor result wrong");
	a_sub_trap: assert property (
		req.valid && req.op == OP_SUB && sub32_ovf |=> exc_reg.valid
		&& exc_reg.cause == CAUSE_OVF && !res_reg.wr_en)
		else $error("sub overflow not trapped");
	a_subu_notrap: assert property (
		q_ok && req_q.op == OP_SUBU |-> !exc_reg.valid && res_reg.wr_en
		&& res_reg.wdata[31:0]
		== 32'(req_q.rs_val - (req_q.use_imm ? req_q.imm : req_q.rt_val)))
		else $error("subu wrong or trapped");
	a_slti_value: assert property (
		q_ok && req_q.op == OP_SLTI |-> res_reg.wdata
		== (($signed(req_q.rs_val) < $signed(req_q.imm)) ? 64'h1 : 64'h0))
		else $error("slti wrong");
	a_sltiu_value: assert property (
		q_ok && req_q.op == OP_SLTIU |-> res_reg.wdata
		== ((req_q.rs_val < req_q.imm) ? 64'h1 : 64'h0))
		else $error("sltiu wrong");
	a_sra_fill: assert property (
		req.valid && req.op == OP_SRA && req.rs_val[31] && req.shamt != 5'h0
		|=> res_reg.wdata[31:30] == 2'b11)
		else $error("sra lost sign");
	a_srl_fill: assert property (
		req.valid && req.op == OP_SRLV && req.rt_val[4:0] != 5'h0
		|=> res_reg.wdata[31] == 1'b0)
		else $error("srl not zero filled");
	a_sll_value: assert property (
		q_ok && req_q.op == OP_SLL
		|-> res_reg.wdata[31:0] == req_q.rs_val[31:0] << req_q.shamt)
		else $error("sll wrong");
	a_xor_value: assert property (
		q_ok && req_q.op == OP_XOR && req_q.use_imm
		|-> res_reg.wdata == (req_q.rs_val ^ req_q.imm))
		else $error("xor wrong");
	a_sys_cause: assert property (
		req.valid && req.op == OP_SYSCALL |=> exc_reg.valid && exc_reg.cause == CAUSE_SYS)
		else $error("syscall not raised");
	a_beql_null: assert property (
		q_ok && req_q.op == OP_BEQL && req_q.rs_val != req_q.rt_val && !req_q.use_imm
		|-> br_reg.resolved && !br_reg.taken && br_reg.nullify)
		else $error("beql not nullified");
	a_link_r31: assert property (
		q_ok && req_q.op == OP_BGEZALL |-> res_reg.wr_en && res_reg.dest == LINK_REG
		&& br_reg.taken == !req_q.rs_val[63])
		else $error("bgezall link wrong");
	a_rfe_pop: assert property (
		req.valid && req.op == OP_RFE
		|=> status_o == {2'($past(sr_reg) >> 4), 4'($past(sr_reg) >> 2)})
		else $error("rfe restore wrong");
	a_cop_branch: assert property (
		q_ok && req_q.op == OP_BCTL |-> br_reg.taken == 1'($past(cp_cond) >> req_q.cop_sel)
		&& br_reg.nullify != br_reg.taken)
		else $error("cop branch wrong");
	a_store_half: assert property (
		q_ok && req_q.op == op_store_half |-> st_reg.valid
		&& (st_reg.be == 4'h3 || st_reg.be == 4'hc)
		&& st_reg.data[15:0] == req_q.rt_val[15:0])
		else $error("halfword store wrong");
	a_store_pair: assert property (
		q_ok && (req_q.op == OP_STORE_LEFT || req_q.op == OP_STORE_RIGHT)
		|-> st_reg.valid && st_reg.be != 4'h0)
		else $error("partial store empty");
	a_dadd_trap: assert property (
		q_ok && req_q.op == OP_DADD |-> exc_reg.valid
		|| (res_reg.wr_en && res_reg.wdata == req_q.rs_val + req_q.rt_val))
		else $error("dadd wrong");
	a_var_low5: assert property (
		q_ok && req_q.op == OP_SRLV
		|-> res_reg.wdata[31:0] == req_q.rs_val[31:0] >> req_q.rt_val[4:0])
		else $error("variable shift count wrong");
	a_ovf_nowrite: assert property (
		exc_reg.valid && exc_reg.cause == CAUSE_OVF |-> !res_reg.wr_en
		&& status_o[1:0] == 2'b00)
		else $error("overflow wrote destination");

	c_sub_ovf: cover property (exc_reg.valid && exc_reg.cause == CAUSE_OVF);
	c_beql_null: cover property (br_reg.resolved && br_reg.nullify);
	c_swl_swr: cover property (st_reg.valid && st_reg.be == 4'h1 ##1 st_reg.valid);
	c_rfe_after: cover property (exc_reg.valid ##[1:8] q_ok && req_q.op == OP_RFE);

endmodule

// ===== tb/ial_issue_model.sv
// pipeline control model: issues decoded instructions to the execute stage
`timescale 1ns/1ns
module ial_issue_model
	import ial_pkg::*;
(
	input  wire logic       mclk,
	output ial_req_t        req,
	output logic      [3:0] cp_cond
);
	initial begin
		req = '0;
		cp_cond = 4'h0;
	end

	// one instruction per falling edge, so consecutive calls issue back to back
	task automatic issue(input ial_req_t r, input logic [3:0] c);
		@(negedge mclk);
		req = r;
		cp_cond = c;
	endtask

	// slow issue: valid drops and the other fields and cp_cond are inverted on each idle cycle
	task automatic idle(input int n);
		ial_req_t r;
		repeat (n) begin
			@(negedge mclk);
			r = ~req;
			r.valid = 1'b0;
			req = r;
			cp_cond = ~cp_cond;
		end
	endtask
endmodule

// ===== tb/test_integer_alu_compare_shift.sv
// self-checking bench for the integer execute stage
`timescale 1ns/1ns
module test_integer_alu_compare_shift;
	import ial_pkg::*;

	logic            mclk = 1'b0;
	logic            rstn = 1'b0;
	ial_req_t        req;
	logic [3:0]      cp_cond;
	ial_res_t        res_o, e_res;
	ial_br_t         br_o, e_br;
	ial_st_t         st_o, e_st;
	ial_exc_t        exc_o, e_exc;
	logic [SR_W-1:0] status_o, sm;
	int              err_count = 0;
	int              comparisons = 0;

	always #2 mclk = ~mclk;

	ial_issue_model ial_issue_model_inst (.mclk(mclk), .req(req), .cp_cond(cp_cond));

	ial_exec ial_exec_inst (
		.mclk(mclk), .rstn(rstn), .req(req), .cp_cond(cp_cond), .res_o(res_o),
		.br_o(br_o), .st_o(st_o), .exc_o(exc_o), .status_o(status_o)
	);

	// ****************************************
	// reference model, one result per taken edge
	// ****************************************
	function automatic logic [63:0] sx32(input logic [31:0] v);
		return {{32{v[31]}}, v};
	endfunction

	task automatic wr(input logic [63:0] d);
		e_res = '{1'b1, req.dest, d};
	endtask

	task automatic trap(input logic [4:0] c);
		e_exc = '{1'b1, c, req.pc};
		sm = {sm[3:0], 2'b00};
	endtask

	task automatic br(input logic tk);
		e_br = '{1'b1, tk, !tk, req.pc + SLOT_OFS + (req.imm << 2)};
	endtask

	task automatic stor(input logic [3:0] be, input logic [31:0] d);
		e_st = '{1'b1, req.rs_val + req.imm, be, d};
	endtask

	always @(posedge mclk or negedge rstn) begin : model
		logic [63:0] b, t;
		logic [31:0] w;
		logic [4:0]  n;
		logic [1:0]  a;
		e_res = '0;
		e_br = '0;
		e_st = '0;
		e_exc = '0;
		b = req.use_imm ? req.imm : req.rt_val;
		a = req.rs_val[1:0] + req.imm[1:0];
		w = req.rt_val[31:0];
		if (!rstn) begin
			sm = SR_RESET;
		end else if (req.valid) begin
			case (req.op)
				OP_NOR: wr(~(req.rs_val | b));
				OP_SUB, OP_SUBU: begin
					t = sx32(req.rs_val[31:0] - b[31:0]);
					if (req.op == OP_SUB && req.rs_val[31] != b[31] && t[31] != req.rs_val[31])
						trap(CAUSE_OVF);
					else
						wr(t);
				end
				OP_SLTI: wr({63'h0, $signed(req.rs_val) < $signed(req.imm)});
				OP_SLTIU: wr({63'h0, req.rs_val < req.imm});
				OP_SRA, OP_SRAV, OP_SRL, OP_SRLV, OP_SLL, OP_SLLV: begin
					n = req.op[0] ? req.rt_val[4:0] : req.shamt;
					w = req.rs_val[31:0];
					if (req.op inside {OP_SLL, OP_SLLV})
						w = w << n;
					else if (req.op inside {OP_SRA, OP_SRAV})
						w = $signed(w) >>> n;
					else
						w = w >> n;
					wr(sx32(w));
				end
				OP_XOR: wr(req.rs_val ^ b);
				OP_SYSCALL: trap(CAUSE_SYS);
				OP_BEQL: br(req.rs_val == b);
				OP_BGEZALL: begin
					br(!req.rs_val[63]);
					e_res = '{1'b1, LINK_REG, req.pc + LINK_OFS};
				end
				OP_BCTL: br(cp_cond[req.cop_sel]);
				OP_BCFL: br(!cp_cond[req.cop_sel]);
				OP_RFE: sm = {sm[5:4], sm[5:2]};
				op_store_word: stor(4'hf, w);
				op_store_half: stor(a[1] ? 4'hc : 4'h3, a[1] ? {w[15:0], 16'h0} : {16'h0, w[15:0]});
				OP_STORE_LEFT: stor(4'hf >> (3 - a), w >> (8 * (3 - a)));
				OP_STORE_RIGHT: stor(4'hf << a, w << (8 * a));
				OP_DADD: begin
					t = req.rs_val + req.rt_val;
					if (req.rs_val[63] == req.rt_val[63] && t[63] != req.rs_val[63])
						trap(CAUSE_OVF);
					else
						wr(t);
				end
				default: ;
			endcase
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// outputs are settled by the falling edge
	always @(negedge mclk) begin : compare
		logic [31:0] m;
		m = {{8{e_st.be[3]}}, {8{e_st.be[2]}}, {8{e_st.be[1]}}, {8{e_st.be[0]}}};
		chk(64'(res_o.wr_en), 64'(e_res.wr_en));
		if (e_res.wr_en) chk(64'(res_o.dest), 64'(e_res.dest));
		if (e_res.wr_en) chk(res_o.wdata, e_res.wdata);
		chk(64'({br_o.resolved, br_o.taken, br_o.nullify}),
			64'({e_br.resolved, e_br.taken, e_br.nullify}));
		if (e_br.taken) chk(br_o.target, e_br.target);
		chk(64'(st_o.valid), 64'(e_st.valid));
		if (e_st.valid) chk({28'h0, st_o.be, st_o.addr[31:0]},
			{28'h0, e_st.be, e_st.addr[31:0]});
		if (e_st.valid) chk(64'(st_o.data & m), 64'(e_st.data & m));
		chk(64'(exc_o.valid), 64'(e_exc.valid));
		if (e_exc.valid) chk(exc_o.epc ^ 64'(exc_o.cause), e_exc.epc ^ 64'(e_exc.cause));
		chk(64'(status_o), 64'(sm));
	end

	// ****************************************
	// stimulus
	// ****************************************
	task automatic go(input ial_op_t op, input logic [63:0] rs, rt, imm,
		input logic ui, input logic [4:0] sh);
		ial_req_t r;
		r = '{1'b1, op, ui, rs, rt, imm, sh, 5'($urandom), 2'($urandom), {$urandom, $urandom}};
		ial_issue_model_inst.issue(r, 4'($urandom));
	endtask

	task automatic end_of_test;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#20000;
		err_count++;
		end_of_test;
	end

	initial begin
		void'($urandom(26196));
		repeat (12) @(negedge mclk);
		rstn = 1'b1;
		go(OP_NOR, 64'hf0f0_0000_ffff_0f0f, 64'h0f00_f0f0_0000_00ff, '0, 0, 0);
		go(OP_SUB, 64'h8000_0000, 64'h1, '0, 0, 0);
		go(OP_SUB, 64'h5, 64'h3, '0, 0, 0);
		go(OP_SUB, 64'h7fff_ffff, '0, 64'hffff_ffff_ffff_ffff, 1, 0);
		go(OP_SUBU, 64'h8000_0000, 64'h1, '0, 0, 0);
		for (int i = 0; i < 2; i++) begin
			go(OP_SLTI, 64'hffff_ffff_ffff_ffff * i, '0, 64'hffff_ffff_ffff_ffff * (1 - i), 1, 0);
			go(OP_SLTIU, 64'hffff_ffff_ffff_ffff * i, '0, 64'hffff_ffff_ffff_ffff * (1 - i), 1, 0);
			go(OP_XOR, 64'hdead_beef_0123_4567, 64'h00ff_00ff, 64'hffff_0000_ffff, 1'(i), 0);
			go(OP_BEQL, 64'h42, 64'h42 + i, 64'h42, 0, 0);
			go(OP_BGEZALL, 64'h8000_0000_0000_0000 * i, '0, 64'h10, 0, 0);
		end
		for (int i = 6; i < 12; i++) begin
			go(ial_op_t'(5'(i)), 64'h8000_0f00, 64'hffff_ffe4, '0, 0, 5'd31);
			go(ial_op_t'(5'(i)), 64'h7000_0001, 64'h3f, '0, 0, 5'd4);
		end
		ial_issue_model_inst.idle(2);
		go(OP_SYSCALL, '0, '0, '0, 0, 0);
		go(OP_RFE, '0, '0, '0, 0, 0);
		for (int i = 0; i < 8; i++) go(i[0] ? OP_BCFL : OP_BCTL, '0, '0, 64'h4, 0, 0);
		for (int i = 0; i < 16; i++)
			go(ial_op_t'(5'(19 + i / 4)), 64'(4096 + i % 4), 64'h1122_3344, '0, 0, 0);
		go(OP_DADD, 64'h7fff_ffff_ffff_ffff, 64'h1, '0, 0, 0);
		go(OP_DADD, 64'h8000_0000_0000_0000, 64'hffff_ffff_ffff_ffff, '0, 0, 0);
		go(OP_DADD, 64'h1234, '0, 64'h10, 1, 0);
		for (int i = 0; i < 2000; i++) begin
			go(ial_op_t'(5'($urandom)), {$urandom, $urandom}, {$urandom, $urandom},
				{$urandom, $urandom}, 1'($urandom), 5'($urandom));
			if (i % 100 == 99) ial_issue_model_inst.idle(2);
		end
		ial_issue_model_inst.idle(3);
		end_of_test;
	end
endmodule
